// ===== src/rtcc_consts.svh
// register word indices, field positions, reset values and timing counts
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH
`define RTCC_IDX_TCTL 8'h04
`define RTCC_IDX_OCTL 8'h05
`define RTCC_IDX_IRQ_STAT 8'h10
`define RTCC_IDX_IRQ_CLR 8'h11
`define RTCC_IDX_IRQ_EN 8'h12
`define RTCC_IDX_ALARM 8'h13
`define RTCC_IDX_SETVAL 8'h14
`define RTCC_IDX_CAPVAL 8'h15
`define RTCC_IDX_COUNT 8'h16
`define RTCC_IDX_OSCSTAT 8'h17
`define RTCC_B_OSC_EN 7
`define RTCC_B_MISS_EN 6
`define RTCC_B_FAIL 5
`define RTCC_B_RUN 4
`define RTCC_B_AEN 3
`define RTCC_B_ALARM 2
`define RTCC_B_SET 1
`define RTCC_B_CAP 0
`define RTCC_B_AGC 7
`define RTCC_B_MODE 6
`define RTCC_B_BIAS2 5
`define RTCC_B_VALID 4
`define RTCC_B_LFO 3
`define RTCC_TCTL_RESET 8'h00
`define RTCC_OCTL_RESET 8'h00
`define RTCC_OCTL_WMASK 8'he8
`define RTCC_IRQ_W 4
`define RTCC_IRQ_ALARM 0
`define RTCC_IRQ_SET 1
`define RTCC_IRQ_CAP 2
`define RTCC_IRQ_FAIL 3
`define RTCC_SET_CYCLES 4'h2
`endif

// ===== src/rtcc_pkg.sv
// types shared by the real-time clock control block
package rtcc_pkg;
    // handshake sequencer states, gray coded along idle-load-done
    typedef enum logic [1:0] {
        RTCC_IDLE = 2'b00,
        RTCC_LOAD = 2'b01,
        RTCC_DONE = 2'b11
    } rtcc_hs_e;
    // analog oscillator controls leaving the block
    typedef struct packed {
        logic oscEnable;
        logic gainControl;
        logic crystalMode;
        logic biasDouble;
        logic lowFreqOsc;
    } rtcc_osc_s;
endpackage

// ===== src/rtcc_sync.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module rtcc_sync (
    // clock and reset
    input wire logic clock,
    input wire logic resetN,
    // level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_q; // first stage, read only by the second
    // two stages, constant reset
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            meta_q <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // rtcc_sync

// ===== src/rtcc_timer.sv
// 32-bit clock timer with hold, load and capture
`timescale 1ns/10ps
module rtcc_timer #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetN,
    // control
    input wire logic run,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire logic capture,
    // results
    output logic [WIDTH-1:0] count,
    output logic [WIDTH-1:0] captured
);
    // count advances only while running; load takes priority, otherwise stopped holds the value
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            count <= '0;
        end else if (load) begin
            count <= loadValue;
        end else if (run) begin
            count <= count + WIDTH'(1);
        end
    end
    // snapshot of the count on request
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            captured <= '0;
        end else if (capture) begin
            captured <= count;
        end
    end
endmodule // rtcc_timer

// ===== src/rtcc_ctrl.sv
// real-time clock timer control and oscillator configuration, apb slave
//
// Behaviour
// - top control bit powers oscillator and bias
// - writing alarm position sets auto reset
// - alarm position reads live alarm event
// - alarm event lasts at most one cycle
// - set bit loads timer, then self-clears
// - capture bit copies count, then self-clears
// - top oscillator bit enables gain control
// - mode bit: zero self-oscillate, one crystal
// - bias double bit doubles oscillator bias
// - valid bit shows sufficient oscillation amplitude
// - low-frequency select overrides mode bit
// - low three oscillator bits read zero
// - oscillator register resets zero, index five
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "rtcc_consts.svh"
module rtcc_ctrl #(
    parameter int TW = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator pins and analog status
    input wire logic amplitudeOk,
    input wire logic missingClock,
    output rtcc_pkg::rtcc_osc_s oscCtl,
    // interrupt
    output logic irq
);
    logic rstMeta_q; // reset release stage one
    logic resetN; // synchronised reset
    logic ampSync; // amplitude ok, synchronised
    logic missSync; // missing clock, synchronised
    logic [7:0] tctl_q; // control bits other than live ones
    logic [7:0] octl_q; // oscillator control storage
    logic alarmEvt_q; // one-cycle alarm event
    logic failFlag_q; // sticky oscillator failure
    logic [TW-1:0] alarm_q; // alarm compare value
    logic [TW-1:0] setVal_q; // value for set operation
    logic [`RTCC_IRQ_W-1:0] irqStat_q; // sticky events
    logic [`RTCC_IRQ_W-1:0] irqEn_q; // event enables
    rtcc_pkg::rtcc_hs_e setSt_q; // set handshake state
    logic capBusy_q; // capture in progress
    logic [TW-1:0] count; // live timer count
    logic [TW-1:0] captured; // captured count
    logic wrEn; // apb write access phase
    logic [9:0] idx; // word index
    logic [7:0] tctlRd; // control read view
    logic [7:0] octlRd; // oscillator read view
    logic [31:0] rdData; // read mux
    logic mapped; // address hits a register
    logic alarmHit; // compare match
    logic setDone; // set finishing pulse
    logic capDone; // capture finishing pulse
    logic [`RTCC_IRQ_W-1:0] events; // this cycle's events

    // release reset through two stages; assert stays asynchronous
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_q <= 1'b0;
            resetN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            resetN <= rstMeta_q;
        end
    end

    // outside levels pass two flip-flops before use
    rtcc_sync uAmp (
        .clock(clock),
        .resetN(resetN),
        .asyncIn(amplitudeOk),
        .syncOut(ampSync)
    );
    rtcc_sync uMiss (
        .clock(clock),
        .resetN(resetN),
        .asyncIn(missingClock),
        .syncOut(missSync)
    );

    // bus decode; zero-wait slave, word aligned
    assign idx = paddr[11:2];
    assign wrEn = psel && penable && pwrite;
    assign setDone = (setSt_q == rtcc_pkg::RTCC_DONE);
    assign capDone = capBusy_q;
    assign alarmHit = tctl_q[`RTCC_B_AEN] && (count == alarm_q)
        && tctl_q[`RTCC_B_RUN];

    // timer core; auto reset loads zero on the match edge itself,
    // so the count never runs past the alarm value
    rtcc_timer #(.WIDTH(TW)) uTimer (
        .clock(clock),
        .resetN(resetN),
        .run(tctl_q[`RTCC_B_RUN]),
        .load(setSt_q == rtcc_pkg::RTCC_LOAD || (alarmHit
            && tctl_q[`RTCC_B_ALARM])),
        .loadValue((setSt_q == rtcc_pkg::RTCC_LOAD) ? setVal_q : '0),
        .capture(capBusy_q),
        .count(count),
        .captured(captured)
    );

    // control register: stored bits, set and capture self-clear
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            tctl_q <= `RTCC_TCTL_RESET;
        end else begin
            if (wrEn && idx == 10'(`RTCC_IDX_TCTL)) begin
                tctl_q[`RTCC_B_OSC_EN] <= pwdata[`RTCC_B_OSC_EN];
                tctl_q[`RTCC_B_MISS_EN] <= pwdata[`RTCC_B_MISS_EN];
                tctl_q[`RTCC_B_RUN] <= pwdata[`RTCC_B_RUN];
                tctl_q[`RTCC_B_AEN] <= pwdata[`RTCC_B_AEN];
                // write side of the alarm position is auto reset
                tctl_q[`RTCC_B_ALARM] <= pwdata[`RTCC_B_ALARM];
            end
            // set and capture: write 1 starts, hardware clears
            if (wrEn && idx == 10'(`RTCC_IDX_TCTL)
                && pwdata[`RTCC_B_SET] && setSt_q == rtcc_pkg::RTCC_IDLE) begin
                tctl_q[`RTCC_B_SET] <= 1'b1;
            end else if (setDone) begin
                tctl_q[`RTCC_B_SET] <= 1'b0;
            end
            if (wrEn && idx == 10'(`RTCC_IDX_TCTL)
                && pwdata[`RTCC_B_CAP] && !capBusy_q) begin
                tctl_q[`RTCC_B_CAP] <= 1'b1;
            end else if (capDone) begin
                tctl_q[`RTCC_B_CAP] <= 1'b0;
            end
            tctl_q[`RTCC_B_FAIL] <= 1'b0; // live flag kept apart
        end
    end

    // set sequencer: start, one load cycle, done clears the bit
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            setSt_q <= rtcc_pkg::RTCC_IDLE;
        end else begin
            case (setSt_q)
                rtcc_pkg::RTCC_IDLE: begin
                    if (tctl_q[`RTCC_B_SET]) begin
                        setSt_q <= rtcc_pkg::RTCC_LOAD;
                    end
                end
                rtcc_pkg::RTCC_LOAD: begin
                    setSt_q <= rtcc_pkg::RTCC_DONE;
                end
                rtcc_pkg::RTCC_DONE: begin
                    setSt_q <= rtcc_pkg::RTCC_IDLE;
                end
                default: begin
                    setSt_q <= rtcc_pkg::RTCC_IDLE;
                end
            endcase
        end
    end

    // capture takes one cycle once requested
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            capBusy_q <= 1'b0;
        end else begin
            capBusy_q <= tctl_q[`RTCC_B_CAP] && !capBusy_q;
        end
    end

    // alarm event: a single-cycle pulse, never held
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            alarmEvt_q <= 1'b0;
        end else begin
            alarmEvt_q <= alarmHit && !alarmEvt_q;
        end
    end

    // failure flag: detector set wins over software clear
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            failFlag_q <= 1'b0;
        end else if (missSync && tctl_q[`RTCC_B_MISS_EN]) begin
            failFlag_q <= 1'b1;
        end else if (wrEn && idx == 10'(`RTCC_IDX_TCTL)
            && !pwdata[`RTCC_B_FAIL]) begin
            failFlag_q <= 1'b0;
        end
    end

    // oscillator control: only writable bits stored
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            octl_q <= `RTCC_OCTL_RESET;
        end else if (wrEn && idx == 10'(`RTCC_IDX_OCTL)) begin
            octl_q <= pwdata[7:0] & `RTCC_OCTL_WMASK;
        end
    end

    // software value registers
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            alarm_q <= '0;
            setVal_q <= '0;
        end else if (wrEn && idx == 10'(`RTCC_IDX_ALARM)) begin
            alarm_q <= pwdata[TW-1:0];
        end else if (wrEn && idx == 10'(`RTCC_IDX_SETVAL)) begin
            setVal_q <= pwdata[TW-1:0];
        end
    end

    // interrupt status: events set, write-one clears, set wins
    assign events = {failFlag_q, capDone, setDone, alarmEvt_q};
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            irqStat_q <= '0;
            irqEn_q <= '0;
        end else begin
            if (wrEn && idx == 10'(`RTCC_IDX_IRQ_CLR)) begin
                irqStat_q <= (irqStat_q & ~pwdata[`RTCC_IRQ_W-1:0]) | events;
            end else begin
                irqStat_q <= irqStat_q | events;
            end
            if (wrEn && idx == 10'(`RTCC_IDX_IRQ_EN)) begin
                irqEn_q <= pwdata[`RTCC_IRQ_W-1:0];
            end
        end
    end

    // read views
    always_comb begin
        tctlRd = tctl_q;
        tctlRd[`RTCC_B_FAIL] = failFlag_q;
        tctlRd[`RTCC_B_ALARM] = alarmEvt_q;
        octlRd = octl_q;
        octlRd[`RTCC_B_VALID] = ampSync;
        octlRd[2:0] = 3'h0;
    end

    // read mux; unmapped reads zero with an error
    always_comb begin
        rdData = 32'h0;
        mapped = 1'b1;
        case (idx)
            10'(`RTCC_IDX_TCTL): rdData = {24'h0, tctlRd};
            10'(`RTCC_IDX_OCTL): rdData = {24'h0, octlRd};
            10'(`RTCC_IDX_IRQ_STAT): rdData = 32'(irqStat_q);
            10'(`RTCC_IDX_IRQ_CLR): rdData = 32'h0;
            10'(`RTCC_IDX_IRQ_EN): rdData = 32'(irqEn_q);
            10'(`RTCC_IDX_ALARM): rdData = 32'(alarm_q);
            10'(`RTCC_IDX_SETVAL): rdData = 32'(setVal_q);
            10'(`RTCC_IDX_CAPVAL): rdData = 32'(captured);
            10'(`RTCC_IDX_COUNT): rdData = 32'(count);
            default: mapped = 1'b0;
        endcase
    end

    // registered apb answer: ready in the access phase's first cycle
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= rdData;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // oscillator outputs and interrupt, all registered
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            oscCtl <= '0;
            irq <= 1'b0;
        end else begin
            oscCtl.oscEnable <= tctl_q[`RTCC_B_OSC_EN];
            oscCtl.gainControl <= octl_q[`RTCC_B_AGC];
            oscCtl.crystalMode <= octl_q[`RTCC_B_MODE]
                && !octl_q[`RTCC_B_LFO];
            oscCtl.biasDouble <= octl_q[`RTCC_B_BIAS2];
            oscCtl.lowFreqOsc <= octl_q[`RTCC_B_LFO];
            irq <= |(irqStat_q & irqEn_q);
        end
    end

    // alarm event never stands two cycles
    property p_alarm_pulse;
        @(posedge clock) disable iff (!resetN)
        alarmEvt_q |=> !alarmEvt_q;
    endproperty
    a_alarm_pulse: assert property (p_alarm_pulse)
        else $error("alarm event held too long");

    // set bit returns to zero within three cycles
    sequence s_set_start;
        setSt_q == rtcc_pkg::RTCC_IDLE && tctl_q[`RTCC_B_SET];
    endsequence
    property p_set_done;
        @(posedge clock) disable iff (!resetN)
        s_set_start |-> ##[1:3] !tctl_q[`RTCC_B_SET];
    endproperty
    a_set_done: assert property (p_set_done)
        else $error("set bit not cleared");

    // capture copies count and clears
    property p_cap;
        @(posedge clock) disable iff (!resetN)
        capBusy_q |=> captured == $past(count) && !tctl_q[`RTCC_B_CAP];
    endproperty
    a_cap: assert property (p_cap)
        else $error("capture wrong");

    // stopped timer holds
    property p_hold;
        @(posedge clock) disable iff (!resetN)
        !tctl_q[`RTCC_B_RUN] && setSt_q != rtcc_pkg::RTCC_LOAD
        |=> count == $past(count);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stopped timer moved");

    // failure flag sticks while no clear write
    property p_fail;
        @(posedge clock) disable iff (!resetN)
        failFlag_q && !(wrEn && idx == 10'(`RTCC_IDX_TCTL)) |=> failFlag_q;
    endproperty
    a_fail: assert property (p_fail)
        else $error("failure flag lost");

    // low oscillator bits always zero
    property p_low0;
        @(posedge clock) disable iff (!resetN)
        octlRd[2:0] == 3'h0 && octl_q[2:0] == 3'h0;
    endproperty
    a_low0: assert property (p_low0)
        else $error("reserved bits set");

    // low frequency select forces crystal mode off
    property p_lfo;
        @(posedge clock) disable iff (!resetN)
        octl_q[`RTCC_B_LFO] |=> oscCtl.lowFreqOsc && !oscCtl.crystalMode;
    endproperty
    a_lfo: assert property (p_lfo)
        else $error("lfo override failed");

    // gain and bias follow register
    property p_agc;
        @(posedge clock) disable iff (!resetN)
        ##1 oscCtl.gainControl == $past(octl_q[`RTCC_B_AGC])
        && oscCtl.biasDouble == $past(octl_q[`RTCC_B_BIAS2]);
    endproperty
    a_agc: assert property (p_agc)
        else $error("oscillator control mismatch");
endmodule // rtcc_ctrl

// ===== tb/rtcc_ctrl_tb.sv
// self-checking testbench for the real-time clock control block
`timescale 1ns/10ps
`include "rtcc_consts.svh"
// compare, count and report one value
`define CHECK(got, exp) begin \
    samplesChecked++; \
    if ((got) !== (exp)) begin \
        numErrors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module rtcc_ctrl_tb;
    // clock, reset and apb master signals
    logic clock;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // analog status inputs and block outputs
    logic amplitudeOk;
    logic missingClock;
    rtcc_pkg::rtcc_osc_s oscCtl;
    logic irq;
    // results of the last transfer
    logic [31:0] rdData;
    logic rdErr;
    int numErrors;
    int samplesChecked;

    rtcc_ctrl dut (
        .clock(clock),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .amplitudeOk(amplitudeOk),
        .missingClock(missingClock),
        .oscCtl(oscCtl),
        .irq(irq)
    );

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // step to the next rising edge; outputs read here hold their
    // pre-edge value, drives made here go out by nba
    task tick;
        @(posedge clock);
    endtask

    // one apb transfer; waits for pready under a bounded count
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        tick();
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        tick();
        penable <= 1'b1;
        n = 0;
        do begin
            tick();
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHECK(pready, 1'b1)
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // read then compare a whole register
    task rdChk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        `CHECK(rdData, exp)
    endtask

    // poll one self-clearing control bit until hardware drops it
    task pollClear(input int bitPos);
        int n;
        n = 0;
        do begin
            apb(1'b0, `RTCC_IDX_TCTL, 32'h0);
            n++;
        end while (rdData[bitPos] !== 1'b0 && n < 20);
        `CHECK(rdData[bitPos], 1'b0)
    endtask

    // reset values of both control registers and the oscillator outputs
    task testReset;
        rdChk(`RTCC_IDX_OCTL, 32'h0);
        rdChk(`RTCC_IDX_TCTL, 32'h0);
        `CHECK(oscCtl, 5'h00)
    endtask

    // oscillator options, read-only bits and the valid indicator
    task testOsc;
        apb(1'b1, `RTCC_IDX_OCTL, 32'hff);
        rdChk(`RTCC_IDX_OCTL, 32'he8);
        `CHECK(oscCtl.gainControl, 1'b1)
        `CHECK(oscCtl.biasDouble, 1'b1)
        `CHECK(oscCtl.lowFreqOsc, 1'b1)
        apb(1'b1, `RTCC_IDX_OCTL, 32'h40);
        // outputs follow the register one edge after the write
        repeat (2) tick();
        `CHECK(oscCtl, 5'h04)
        apb(1'b1, `RTCC_IDX_OCTL, 32'h00);
        repeat (2) tick();
        `CHECK(oscCtl.crystalMode, 1'b0)
        amplitudeOk <= 1'b1;
        repeat (4) tick();
        rdChk(`RTCC_IDX_OCTL, 32'h10);
        amplitudeOk <= 1'b0;
        repeat (4) tick();
        rdChk(`RTCC_IDX_OCTL, 32'h00);
        // unmapped index answers with an error and zero data
        apb(1'b0, 8'h3f, 32'h0);
        `CHECK({rdErr, rdData}, 33'h100000000)
    endtask

    // set, capture and hold of the timer count
    task testSetCap;
        apb(1'b1, `RTCC_IDX_SETVAL, 32'h100);
        apb(1'b1, `RTCC_IDX_TCTL, 32'h82);
        repeat (2) tick();
        `CHECK(oscCtl.oscEnable, 1'b1)
        pollClear(`RTCC_B_SET);
        rdChk(`RTCC_IDX_COUNT, 32'h100);
        rdChk(`RTCC_IDX_COUNT, 32'h100);
        apb(1'b1, `RTCC_IDX_TCTL, 32'h90);
        repeat (10) tick();
        apb(1'b1, `RTCC_IDX_TCTL, 32'h81);
        pollClear(`RTCC_B_CAP);
        apb(1'b0, `RTCC_IDX_COUNT, 32'h0);
        `CHECK(rdData > 32'h100, 1'b1)
        rdChk(`RTCC_IDX_CAPVAL, rdData);
        rdChk(`RTCC_IDX_COUNT, rdData);
        apb(1'b1, `RTCC_IDX_TCTL, 32'h00);
        repeat (2) tick();
        `CHECK(oscCtl.oscEnable, 1'b0)
    endtask

    // alarm with and without auto reset, alarm interrupt and masking
    task testAlarm;
        apb(1'b1, `RTCC_IDX_IRQ_CLR, 32'hf);
        apb(1'b1, `RTCC_IDX_SETVAL, 32'h0);
        apb(1'b1, `RTCC_IDX_ALARM, 32'h5);
        apb(1'b1, `RTCC_IDX_TCTL, 32'h82);
        pollClear(`RTCC_B_SET);
        apb(1'b1, `RTCC_IDX_TCTL, 32'h9c);
        repeat (30) tick();
        apb(1'b0, `RTCC_IDX_COUNT, 32'h0);
        `CHECK(rdData <= 32'h5, 1'b1)
        apb(1'b0, `RTCC_IDX_IRQ_STAT, 32'h0);
        `CHECK(rdData[`RTCC_IRQ_ALARM], 1'b1)
        apb(1'b1, `RTCC_IDX_TCTL, 32'h98);
        repeat (30) tick();
        apb(1'b0, `RTCC_IDX_COUNT, 32'h0);
        `CHECK(rdData > 32'h5, 1'b1)
        apb(1'b1, `RTCC_IDX_TCTL, 32'h00);
        apb(1'b1, `RTCC_IDX_IRQ_EN, 32'h1);
        repeat (2) tick();
        `CHECK(irq, 1'b1)
        apb(1'b1, `RTCC_IDX_IRQ_EN, 32'h0);
        repeat (2) tick();
        `CHECK(irq, 1'b0)
        apb(1'b1, `RTCC_IDX_IRQ_CLR, 32'hf);
        rdChk(`RTCC_IDX_IRQ_STAT, 32'h0);
    endtask

    // sticky failure flag, software clear and failure interrupt
    task testFail;
        apb(1'b1, `RTCC_IDX_TCTL, 32'hc0);
        missingClock <= 1'b1;
        repeat (6) tick();
        missingClock <= 1'b0;
        repeat (6) tick();
        // flag must outlive the detector pulse
        rdChk(`RTCC_IDX_TCTL, 32'he0);
        apb(1'b1, `RTCC_IDX_IRQ_EN, 32'h8);
        repeat (2) tick();
        `CHECK(irq, 1'b1)
        apb(1'b1, `RTCC_IDX_TCTL, 32'hc0);
        rdChk(`RTCC_IDX_TCTL, 32'hc0);
        apb(1'b1, `RTCC_IDX_IRQ_CLR, 32'h8);
        repeat (2) tick();
        `CHECK(irq, 1'b0)
        rdChk(`RTCC_IDX_IRQ_STAT, 32'h0);
    endtask

    // verdict and end of run
    task finish_test;
        $display("errors=%0d checks=%0d", numErrors, samplesChecked);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs far fewer cycles than this
    initial begin
        repeat (50000) @(posedge clock);
        numErrors++;
        finish_test();
    end

    // main sequence
    initial begin
        numErrors = 0;
        samplesChecked = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        amplitudeOk = 1'b0;
        missingClock = 1'b0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) tick();
        testReset();
        testOsc();
        testSetCap();
        testAlarm();
        testFail();
        finish_test();
    end
endmodule // rtcc_ctrl_tb
